// File: logic/eip_defines.svh
// Constants for the second-bank interrupt priority and external request block.
// Assumes inclusion by bare name from files under logic/.
`ifndef EIP_DEFINES_SVH
`define EIP_DEFINES_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define EIP_OFS_CTRL 8'h88
`define EIP_OFS_PRIO_HIGH 8'hF7
`define EIP_OFS_PRIO_LOW 8'hFF

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define EIP_BIT_REQ1_FLAG 3
`define EIP_BIT_REQ1_TYPE 2
`define EIP_BIT_REQ0_FLAG 1
`define EIP_BIT_REQ0_TYPE 0

// ------------------------------------------------------------
// Priority fields and reset values
// ------------------------------------------------------------
`define EIP_PRIO_MASK 8'hF3
`define EIP_RST_PRIO_HIGH 8'h00
`define EIP_RST_PRIO_LOW 8'h00
`define EIP_RST_CTRL 8'h00

`endif

// File: logic/eip_ext_req.sv
// One external request input: synchroniser, falling-edge detector and flag.
// Assumes the pin is asynchronous to clock; clearing inputs are clock-domain pulses.
`include "eip_defines.svh"

module eip_ext_req (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Pin and control
   input wire logic pin_n,
   input wire logic trig_edge,
   input wire logic clr,
   // Flag
   output logic flag
);

   logic sync1_r, sync2_r, prev_r, flag_r;
   logic flag_nxt;
   logic fall;

   // ------------------------------------------------------------
   // Synchroniser and edge detect
   // ------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         prev_r <= 1'b1;
      end else begin
         sync1_r <= pin_n;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   assign fall = prev_r & ~sync2_r;

   // ------------------------------------------------------------
   // Flag
   // ------------------------------------------------------------
   always_comb begin
      if (trig_edge) begin
         // A new edge wins over a clear in the same cycle
         flag_nxt = fall | (flag_r & ~clr);
      end else begin
         // Level mode follows the inverted pin; latched state is dropped
         flag_nxt = ~sync2_r;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign flag = flag_r;

endmodule

// File: logic/eip_pkg.sv
// Types shared by the second-bank priority block.
// Assumes eip_defines.svh is compiled alongside.
package eip_pkg;

   // Two-bit arbitration level, 3 is highest
   typedef logic [1:0] eip_level_t;

   // Levels of the six sources in the second group
   typedef struct packed {
      eip_level_t timer2;
      eip_level_t serial_periph;
      eip_level_t brake;
      eip_level_t watchdog;
      eip_level_t keypad;
      eip_level_t i2c;
   } eip_levels_s;

   // Per-pin request flags toward the core
   typedef struct packed {
      logic req1;
      logic req0;
   } eip_flags_s;

   // Trigger type of an external request
   typedef enum logic {
      EIP_TRIG_LEVEL = 1'b0,
      EIP_TRIG_EDGE = 1'b1
   } eip_trig_e;

endpackage

// File: logic/eip_top.sv
// Second-group interrupt priority registers and external request flags.
// Assumes a classic Wishbone master on clock; pins are asynchronous.
//
// Contract
// - Low-priority bits raise six sources one level
// - High-priority bits raise sources two levels
// - Bits 3:2 of priority registers reserved
// - Request 1 flag set on chosen condition
// - Edge flag 1 holds until cleared or serviced
// - Level mode: flag 1 is inverted pin
// - Bit 2 selects level or falling edge
// - Request 0 flag at bit 1 set
// - Edge flag 0 holds until cleared or serviced
// - Level mode: flag 0 is inverted pin
// - Bit 0 selects level or falling edge
`include "eip_defines.svh"

module eip_top (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // External request pins, active low
   input wire logic ext_req0_pin_n,
   input wire logic ext_req1_pin_n,
   // Core service acknowledge pulses
   input wire logic ext_req0_serviced,
   input wire logic ext_req1_serviced,
   // Toward the core
   output eip_pkg::eip_flags_s ext_flags,
   output eip_pkg::eip_levels_s src_levels
);

   logic [7:0] prio_high_r, prio_high_nxt;
   logic [7:0] prio_low_r, prio_low_nxt;
   logic ext_req1_trigger_type_r, ext_req1_trigger_type_nxt;
   logic ext_req0_trigger_type_r, ext_req0_trigger_type_nxt;
   logic [5:0] ctrl_hi_r, ctrl_hi_nxt;
   logic ack_r, ack_nxt;
   logic err_r, err_nxt;
   logic [31:0] dat_r, dat_nxt;
   eip_pkg::eip_levels_s levels_r, levels_nxt;
   eip_pkg::eip_flags_s flags_r;
   logic ext_req0_flag, ext_req1_flag;
   logic clr0, clr1;
   logic req, wr_lane0, hit_ctrl, hit_high, hit_low;
   logic [7:0] ctrl_view;

   // Two-bit level from a high and a low bit, high dominates
   function automatic eip_pkg::eip_level_t mk_level(input logic hi, input logic lo);
      mk_level = {hi, lo};
   endfunction

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // Requests are answered one cycle after they appear; ack_r blocks a re-take
   assign req = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
   assign wr_lane0 = req & wb_we_i & wb_sel_i[0];
   assign hit_ctrl = (wb_adr_i == `EIP_OFS_CTRL);
   assign hit_high = (wb_adr_i == `EIP_OFS_PRIO_HIGH);
   assign hit_low = (wb_adr_i == `EIP_OFS_PRIO_LOW);

   // Software clearing the flag: write of 0 to the flag bit
   assign clr1 = (wr_lane0 & hit_ctrl & ~wb_dat_i[`EIP_BIT_REQ1_FLAG])
      | ext_req1_serviced;
   assign clr0 = (wr_lane0 & hit_ctrl & ~wb_dat_i[`EIP_BIT_REQ0_FLAG])
      | ext_req0_serviced;

   assign ctrl_view = {ctrl_hi_r[5:2], ext_req1_flag, ext_req1_trigger_type_r,
      ext_req0_flag, ext_req0_trigger_type_r};

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   always_comb begin
      prio_high_nxt = prio_high_r;
      prio_low_nxt = prio_low_r;
      ext_req1_trigger_type_nxt = ext_req1_trigger_type_r;
      ext_req0_trigger_type_nxt = ext_req0_trigger_type_r;
      ctrl_hi_nxt = ctrl_hi_r;
      ack_nxt = 1'b0;
      err_nxt = 1'b0;
      dat_nxt = dat_r;
      if (req) begin
         if (hit_ctrl | hit_high | hit_low) begin
            ack_nxt = 1'b1;
         end else begin
            ack_nxt = 1'b0;
            err_nxt = 1'b1;
         end
         dat_nxt = 32'h0000_0000;
         if (hit_ctrl) begin
            dat_nxt[7:0] = ctrl_view;
         end else if (hit_high) begin
            dat_nxt[7:0] = prio_high_r;
         end else if (hit_low) begin
            dat_nxt[7:0] = prio_low_r;
         end
      end
      if (wr_lane0) begin
         if (hit_high) begin
            prio_high_nxt = wb_dat_i[7:0] & `EIP_PRIO_MASK;
         end
         if (hit_low) begin
            prio_low_nxt = wb_dat_i[7:0] & `EIP_PRIO_MASK;
         end
         if (hit_ctrl) begin
            // Timer bits are stored only; timer logic lives elsewhere
            ctrl_hi_nxt = {wb_dat_i[7:4], 2'b00};
            ext_req1_trigger_type_nxt = wb_dat_i[`EIP_BIT_REQ1_TYPE];
            ext_req0_trigger_type_nxt = wb_dat_i[`EIP_BIT_REQ0_TYPE];
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prio_high_r <= `EIP_RST_PRIO_HIGH;
         prio_low_r <= `EIP_RST_PRIO_LOW;
         ext_req1_trigger_type_r <= 1'b0;
         ext_req0_trigger_type_r <= 1'b0;
         ctrl_hi_r <= 6'h00;
         ack_r <= 1'b0;
         err_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         prio_high_r <= prio_high_nxt;
         prio_low_r <= prio_low_nxt;
         ext_req1_trigger_type_r <= ext_req1_trigger_type_nxt;
         ext_req0_trigger_type_r <= ext_req0_trigger_type_nxt;
         ctrl_hi_r <= ctrl_hi_nxt;
         ack_r <= ack_nxt;
         err_r <= err_nxt;
         dat_r <= dat_nxt;
      end
   end

   // ------------------------------------------------------------
   // Priority levels
   // ------------------------------------------------------------
   always_comb begin
      levels_nxt.timer2 = mk_level(prio_high_r[7], prio_low_r[7]);
      levels_nxt.serial_periph = mk_level(prio_high_r[6], prio_low_r[6]);
      levels_nxt.brake = mk_level(prio_high_r[5], prio_low_r[5]);
      levels_nxt.watchdog = mk_level(prio_high_r[4], prio_low_r[4]);
      levels_nxt.keypad = mk_level(prio_high_r[1], prio_low_r[1]);
      levels_nxt.i2c = mk_level(prio_high_r[0], prio_low_r[0]);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         levels_r <= '0;
      end else begin
         levels_r <= levels_nxt;
      end
   end

   // ------------------------------------------------------------
   // External requests
   // ------------------------------------------------------------
   eip_ext_req u_req1 (
      .clock(clock),
      .rst(rst),
      .pin_n(ext_req1_pin_n),
      .trig_edge(ext_req1_trigger_type_r),
      .clr(clr1),
      .flag(ext_req1_flag)
   );

   eip_ext_req u_req0 (
      .clock(clock),
      .rst(rst),
      .pin_n(ext_req0_pin_n),
      .trig_edge(ext_req0_trigger_type_r),
      .clr(clr0),
      .flag(ext_req0_flag)
   );

   // Flag outputs come straight from the flag flip-flops inside the leaves
   always_comb begin
      flags_r.req1 = ext_req1_flag;
      flags_r.req0 = ext_req0_flag;
   end

   assign ext_flags = flags_r;
   assign src_levels = levels_r;
   assign wb_ack_o = ack_r;
   assign wb_err_o = err_r;
   assign wb_dat_o = dat_r;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_bus_req;
      wb_cyc_i && wb_stb_i && !ack_r && !err_r;
   endsequence

   a_prio_reserved_zero: assert property (prio_high_r[3:2] == 2'b00 && prio_low_r[3:2] == 2'b00)
      else $error("Reserved priority bits not zero");
   a_low_write_level: assert property (s_bus_req and (wb_we_i && wb_sel_i[0] && hit_low)
      |-> ##2 levels_r.timer2[0] == $past(wb_dat_i[7], 2))
      else $error("Timer2 low bit not reflected in level");
   a_high_write_level: assert property (s_bus_req and (wb_we_i && wb_sel_i[0] && hit_high)
      |-> ##2 levels_r.i2c[1] == $past(wb_dat_i[0], 2))
      else $error("I2C high bit not reflected in level");
   a_level_order: assert property (levels_r.watchdog == {$past(prio_high_r[4]),
      $past(prio_low_r[4])})
      else $error("Watchdog level ordering wrong");
   a_lvl1_tracks_pin: assert property (!ext_req1_trigger_type_r && $stable(ext_req1_trigger_type_r)
      && $stable(ext_req1_pin_n) [*4] |-> ext_req1_flag == !ext_req1_pin_n)
      else $error("Level flag 1 not inverse of pin");
   a_lvl0_tracks_pin: assert property (!ext_req0_trigger_type_r && $stable(ext_req0_trigger_type_r)
      && $stable(ext_req0_pin_n) [*4] |-> ext_req0_flag == !ext_req0_pin_n)
      else $error("Level flag 0 not inverse of pin");
   a_edge1_holds: assert property (ext_req1_trigger_type_r && ext_req1_flag && !clr1
      && $stable(ext_req1_trigger_type_r) |=> ext_req1_flag)
      else $error("Edge flag 1 dropped without clear");
   a_edge0_holds: assert property (ext_req0_trigger_type_r && ext_req0_flag && !clr0
      && $stable(ext_req0_trigger_type_r) |=> ext_req0_flag)
      else $error("Edge flag 0 dropped without clear");
   a_edge1_sets: assert property (ext_req1_trigger_type_r [*6] ##0 $fell(ext_req1_pin_n)
      ##1 !ext_req1_pin_n [*3] |=> ext_req1_flag)
      else $error("Falling edge on pin 1 not flagged");
   a_edge0_sets: assert property (ext_req0_trigger_type_r [*6] ##0 $fell(ext_req0_pin_n)
      ##1 !ext_req0_pin_n [*3] |=> ext_req0_flag)
      else $error("Falling edge on pin 0 not flagged");
   a_type_write: assert property (s_bus_req and (wb_we_i && wb_sel_i[0] && hit_ctrl)
      |=> ext_req1_trigger_type_r == $past(wb_dat_i[2])
      && ext_req0_trigger_type_r == $past(wb_dat_i[0]))
      else $error("Trigger type bits not written");

endmodule

// File: testbench/eip_core_model.sv
// Model of the core and the two request pins seen by the priority block.
// Assumes the bench commands pin levels and service starts on clock.
module eip_core_model (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Commands from the bench, flags from the block
   input wire logic [1:0] pin_lvl,
   input wire logic [1:0] svc_req,
   input wire eip_pkg::eip_flags_s flags,
   // Toward the block
   output logic pin0_n,
   output logic pin1_n,
   output logic svc0,
   output logic svc1
);
   timeunit 1ns;
   timeprecision 100ps;

   // Pins are always driven, so no released state exists
   assign pin0_n = pin_lvl[0];
   assign pin1_n = pin_lvl[1];

   // Service only starts for a pending request, one pulse per command
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         svc0 <= 1'b0;
         svc1 <= 1'b0;
      end else begin
         svc0 <= svc_req[0] & flags.req0;
         svc1 <= svc_req[1] & flags.req1;
      end
   end
endmodule

// File: testbench/test_eip_top.sv
// Self-checking bench for the second-group priority and request block.
// Assumes a 200 MHz clock and the core model beside the block.
module test_eip_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic p0_n, p1_n, sv0, sv1, rq_err;
   logic [1:0] pin_lvl, svc_req;
   logic [7:0] rq, h, l;
   eip_pkg::eip_flags_s ext_flags;
   eip_pkg::eip_levels_s src_levels;
   int err_total, checks_done, cyc_cnt;

   eip_top dut_u (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .ext_req0_pin_n(p0_n), .ext_req1_pin_n(p1_n), .ext_req0_serviced(sv0),
      .ext_req1_serviced(sv1), .ext_flags(ext_flags), .src_levels(src_levels));

   eip_core_model core_u (.clock(clock), .rst(rst), .pin_lvl(pin_lvl), .svc_req(svc_req),
      .flags(ext_flags), .pin0_n(p0_n), .pin1_n(p1_n), .svc0(sv0), .svc1(sv1));

   always #2.5 clock = ~clock;

   // ------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Whole run needs under two hundred cycles; the ceiling leaves wide margin
   always @(posedge clock) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         err_total++;
         finish_test();
      end
   end

   // Expected levels: {high,low} per source, high bit dominant
   function automatic logic [11:0] lv(input logic [7:0] hi, input logic [7:0] lo);
      return {hi[7], lo[7], hi[6], lo[6], hi[5], lo[5], hi[4], lo[4], hi[1], lo[1], hi[0], lo[0]};
   endfunction

   // ------------------------------------------------------------
   // Classic Wishbone single cycle
   // ------------------------------------------------------------
   task automatic wb_op(input logic w, input logic [7:0] a, input logic [7:0] d,
                        input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= {24'h00_0000, d};
      do begin
         @(posedge clock);
         n++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 40);
      // A bus that never answers counts as a mismatch
      if (n >= 40) begin
         err_total++;
         $display("BAD t=%0t bus access not answered", $time);
      end
      rq = wb_dat_o[7:0];
      rq_err = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      pin_lvl = 2'b11;
      svc_req = 2'b00;
      err_total = 0;
      checks_done = 0;
      cyc_cnt = 0;
      void'($urandom(8461));
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      wb_op(1'b0, 8'hF7, 8'h00, 4'hF);
      chk(rq, 8'h00);
      wb_op(1'b0, 8'h88, 8'h00, 4'hF);
      chk(rq, 8'h00);
      chk(src_levels, 12'h000);
      for (int i = 0; i < 6; i++) begin
         h = (i == 0) ? 8'h0C : 8'($urandom);
         l = (i == 0) ? 8'hFF : 8'($urandom);
         wb_op(1'b1, 8'hF7, h, 4'hF);
         wb_op(1'b1, 8'hFF, l, 4'hF);
         wb_op(1'b0, 8'hF7, 8'h00, 4'hF);
         chk(rq, h & 8'hF3);
         wb_op(1'b0, 8'hFF, 8'h00, 4'hF);
         chk(rq, l & 8'hF3);
         chk(src_levels, lv(h, l));
      end
      // Lane 0 off: write is answered but must not land
      wb_op(1'b1, 8'hF7, ~h, 4'hE);
      wb_op(1'b0, 8'hF7, 8'h00, 4'hF);
      chk(rq, h & 8'hF3);
      wb_op(1'b0, 8'h90, 8'h00, 4'hF);
      chk(rq_err, 1'b1);
      // Level mode on both pins
      wb_op(1'b1, 8'h88, 8'h00, 4'hF);
      pin_lvl <= 2'b10;
      repeat (6) @(posedge clock);
      chk(ext_flags, 2'b01);
      pin_lvl <= 2'b01;
      repeat (6) @(posedge clock);
      chk(ext_flags, 2'b10);
      pin_lvl <= 2'b11;
      repeat (6) @(posedge clock);
      chk(ext_flags, 2'b00);
      // Edge mode: short low pulse must latch
      wb_op(1'b1, 8'h88, 8'h05, 4'hF);
      pin_lvl <= 2'b00;
      repeat (2) @(posedge clock);
      pin_lvl <= 2'b11;
      repeat (6) @(posedge clock);
      chk(ext_flags, 2'b11);
      wb_op(1'b0, 8'h88, 8'h00, 4'hF);
      chk(rq, 8'h0F);
      wb_op(1'b1, 8'h88, 8'h0D, 4'hF);
      repeat (2) @(posedge clock);
      chk(ext_flags, 2'b10);
      @(posedge clock);
      svc_req <= 2'b10;
      @(posedge clock);
      svc_req <= 2'b00;
      repeat (3) @(posedge clock);
      chk(ext_flags, 2'b00);
      finish_test();
   end
endmodule
